/* File: pkg/tsi_pkg.sv */
package tsi_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NSTREAM   = 8;
  localparam int NCHAN     = 32;
  localparam int MEM_DEPTH = 256;

  // ----------------------------------------------------------------
  // port address decode
  // ----------------------------------------------------------------
  localparam int REGION_LINE_BIT = 5;

  // ----------------------------------------------------------------
  // mode_control fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_SPLIT_BIT  = 7;
  localparam int CTRL_FORCE_BIT  = 6;
  localparam int CTRL_MSEL_HI    = 4;
  localparam int CTRL_MSEL_LO    = 3;
  localparam int CTRL_STREAM_HI  = 2;
  localparam int CTRL_STREAM_LO  = 0;

  localparam logic [1:0] MSEL_NONE = 2'h0;
  localparam logic [1:0] MSEL_DATA = 2'h1;
  localparam logic [1:0] MSEL_LOW  = 2'h2;
  localparam logic [1:0] MSEL_HIGH = 2'h3;

  // ----------------------------------------------------------------
  // channel_control_high / channel_source_low fields
  // ----------------------------------------------------------------
  localparam int CMH_WIDTH   = 3;
  localparam int CMH_SRC_BIT = 2;
  localparam int CMH_EXT_BIT = 1;
  localparam int CMH_OE_BIT  = 0;
  localparam logic [2:0] CMH_RESET = 3'h0;
  localparam logic [7:0] CML_RESET = 8'h00;
  localparam logic [7:0] DM_RESET  = 8'h00;
  localparam int CML_STREAM_HI = 7;
  localparam int CML_STREAM_LO = 5;
  localparam int CML_CHAN_HI   = 4;
  localparam int CML_CHAN_LO   = 0;

  // ----------------------------------------------------------------
  // bus answer timing, in mclk cycles spent waiting before ack
  // ----------------------------------------------------------------
  localparam logic [3:0] ACK_FAST_CYC = 4'h2;
  localparam logic [3:0] ACK_SLOW_CYC = 4'h8;

  // ----------------------------------------------------------------
  // pin synchroniser vector: {ode, rx[7:0], fp_n, bclk, data, addr, rw, cs_n}
  // ----------------------------------------------------------------
  localparam int SYNC_W = 27;
  localparam logic [26:0] SYNC_RESET = 27'h0020001;

  typedef enum {bus_idle, bus_wait, bus_ack} bus_state_t;

endpackage

/* File: pkg/slot_timing_if.sv */
`timescale 1ns/1ps
interface slot_timing_if;
  logic        rx_tick;
  logic [4:0]  chan;
  logic [2:0]  bitpos;
  logic        dm_we;
  logic [4:0]  dm_chan;
  logic [63:0] dm_bytes;

  modport timer (output rx_tick, chan, bitpos, input dm_we, dm_chan, dm_bytes);
  modport rx    (input rx_tick, chan, bitpos, output dm_we, dm_chan, dm_bytes);
endinterface

/* File: src/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  // first stage feeds only the second stage
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

/* File: src/serial_capture.sv */
`timescale 1ns/1ps
module serial_capture import tsi_pkg::*; (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] serial_inputs_i,
  slot_timing_if.rx       tim
);
  logic [7:0]  shift_q [NSTREAM];
  logic [7:0]  shift_d [NSTREAM];
  logic        we_q;
  logic        we_d;
  logic [4:0]  chan_q;
  logic [4:0]  chan_d;
  logic [63:0] bytes_q;
  logic [63:0] bytes_d;

  // msb arrives first; a full byte is handed over at the last bit
  always_comb begin
    shift_d = shift_q;
    we_d    = 1'b0;
    chan_d  = chan_q;
    bytes_d = bytes_q;
    if (tim.rx_tick) begin
      for (int s = 0; s < NSTREAM; s++) begin
        shift_d[s] = {shift_q[s][6:0], serial_inputs_i[s]};
      end
      if (tim.bitpos == 3'h7) begin
        we_d   = 1'b1;
        chan_d = tim.chan;
        for (int s = 0; s < NSTREAM; s++) begin
          bytes_d[s*8 +: 8] = {shift_q[s][6:0], serial_inputs_i[s]};
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int s = 0; s < NSTREAM; s++) begin
        shift_q[s] <= DM_RESET;
      end
      we_q    <= 1'b0;
      chan_q  <= 5'h00;
      bytes_q <= 64'h0;
    end else begin
      shift_q <= shift_d;
      we_q    <= we_d;
      chan_q  <= chan_d;
      bytes_q <= bytes_d;
    end
  end

  assign tim.dm_we    = we_q;
  assign tim.dm_chan  = chan_q;
  assign tim.dm_bytes = bytes_q;
endmodule

/* File: src/tsi_switch_control_memory_map.sv */
`timescale 1ns/1ps
// What this block does
// - region line low hits mode_control; high maps 20-3F to 32 selected channels
// - control writes answer fast; every other port access answers slow
// - forced output bit 6 sends channel_source_low on all channels, unless drive low
// - with bit 6 clear, each channel's own memory bits decide content and drive
// - memory_select 01 data (read only), 10 source low, 11 control high
// - stream_select picks the stream subsection seen at channel addresses
// - control high bits 7-3 have no storage and read zero
// - source bit 1 sends source low byte; 0 uses it as data address
// - external control bit leaves one channel time ahead of its channel
// - external control bits go out in stream order, stream 0 first
// - with drive high and bit 6 clear, control high bit 0 enables driver
// - source low bits 7-5 name the source input stream
// - source low bits 4-0 name the source channel, bit 4 msb
// - forced or source bit set: all 8 source low bits go out unchanged
// - split access: reads from data memory, writes to selected connection memory
// - master drive low holds every serial output high impedance
// - stream 0 channel 0 control bit goes with channel 31 bit 0
module tsi_switch_control_memory_map import tsi_pkg::*; (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic       cs_n_i,
  input  wire logic       rd_wr_i,
  input  wire logic [5:0] addr_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  output logic            ack_n_o,
  output logic            ack_oe_o,
  input  wire logic       serial_bit_clock_i,
  input  wire logic       frame_pulse_n_i,
  input  wire logic [7:0] serial_inputs_i,
  input  wire logic       master_output_drive_i,
  output logic      [7:0] serial_outputs_o,
  output logic      [7:0] serial_outputs_oe_o,
  output logic            external_control_bit_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_s;
  logic              cs_s;
  logic              rw_s;
  logic [5:0]        addr_s;
  logic [7:0]        data_s;
  logic              bclk_s;
  logic              fp_s;
  logic [7:0]        rx_s;
  logic              ode_s;

  pin_sync #(
    .W   (SYNC_W),
    .RST (SYNC_RESET)
  ) u_pin_sync (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .d_i    ({master_output_drive_i, serial_inputs_i, frame_pulse_n_i,
              serial_bit_clock_i, data_i, addr_i, rd_wr_i, cs_n_i}),
    .q_o    (pins_s)
  );

  assign cs_s   = pins_s[0];
  assign rw_s   = pins_s[1];
  assign addr_s = pins_s[7:2];
  assign data_s = pins_s[15:8];
  assign bclk_s = pins_s[16];
  assign fp_s   = pins_s[17];
  assign rx_s   = pins_s[25:18];
  assign ode_s  = pins_s[26];

  // ----------------------------------------------------------------
  // frame timing
  // ----------------------------------------------------------------
  // cnt counts serial clock half-bits: chan = [8:4], bit = [3:1]
  slot_timing_if tim ();

  logic       bclk_d1_q;
  logic       tick_q;
  logic       tick_d;
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic       tx_tick;
  logic [4:0] next_chan;

  always_comb begin
    tick_d = bclk_d1_q & ~bclk_s;
    cnt_d  = cnt_q;
    if (tick_d) begin
      cnt_d = fp_s ? cnt_q + 9'h001 : 9'h000;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bclk_d1_q <= 1'b0;
      tick_q    <= 1'b0;
      cnt_q     <= 9'h000;
    end else begin
      bclk_d1_q <= bclk_s;
      tick_q    <= tick_d;
      cnt_q     <= cnt_d;
    end
  end

  // sample mid-bit, launch at bit start
  assign tim.rx_tick = tick_q & cnt_q[0];
  assign tx_tick     = tick_q & ~cnt_q[0];
  assign tim.chan    = cnt_q[8:4];
  assign tim.bitpos  = cnt_q[3:1];
  assign next_chan   = cnt_q[8:4] + 5'h01;

  // ----------------------------------------------------------------
  // receive into data memory
  // ----------------------------------------------------------------
  logic [7:0] dm_q [MEM_DEPTH];
  logic [7:0] dm_d [MEM_DEPTH];

  serial_capture u_serial_capture (
    .mclk_i          (mclk_i),
    .nrst_i          (nrst_i),
    .serial_inputs_i (rx_s),
    .tim             (tim)
  );

  always_comb begin
    dm_d = dm_q;
    if (tim.dm_we) begin
      for (int s = 0; s < NSTREAM; s++) begin
        dm_d[{3'(s), tim.dm_chan}] = tim.dm_bytes[s*8 +: 8];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        dm_q[i] <= DM_RESET;
      end
    end else begin
      dm_q <= dm_d;
    end
  end

  // ----------------------------------------------------------------
  // processor port and connection memories
  // ----------------------------------------------------------------
  bus_state_t st_q;
  bus_state_t st_d;
  logic [3:0] wait_q;
  logic [3:0] wait_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rd_q;
  logic       rd_d;
  logic [7:0] cml_q [MEM_DEPTH];
  logic [7:0] cml_d [MEM_DEPTH];
  logic [2:0] cmh_q [MEM_DEPTH];
  logic [2:0] cmh_d [MEM_DEPTH];
  logic       take;
  logic       fast_req;
  logic [1:0] msel;
  logic       split;
  logic       force_out;
  logic [7:0] idx;

  assign msel      = ctrl_q[CTRL_MSEL_HI:CTRL_MSEL_LO];
  assign split     = ctrl_q[CTRL_SPLIT_BIT];
  assign force_out = ctrl_q[CTRL_FORCE_BIT];
  assign idx       = {ctrl_q[CTRL_STREAM_HI:CTRL_STREAM_LO], addr_s[4:0]};
  assign take      = (st_q == bus_idle) & ~cs_s;
  assign fast_req  = take & ~rw_s & ~addr_s[REGION_LINE_BIT];

  function automatic logic [7:0] port_read(input logic       spl,
                                           input logic [1:0] ms,
                                           input logic [7:0] dm,
                                           input logic [7:0] channel_source_low,
                                           input logic [2:0] channel_control_high);
    logic [7:0] r;
    r = 8'h00;
    if (spl) begin
      r = dm;
    end else begin
      case (ms)
        MSEL_DATA: r = dm;
        MSEL_LOW:  r = channel_source_low;
        MSEL_HIGH: r = {5'h00, channel_control_high};
        default:   r = 8'h00;
      endcase
    end
    return r;
  endfunction

  always_comb begin
    st_d    = st_q;
    wait_d  = wait_q;
    ctrl_d  = ctrl_q;
    rdata_d = rdata_q;
    rd_d    = rd_q;
    cml_d   = cml_q;
    cmh_d   = cmh_q;
    case (st_q)
      bus_idle: begin
        if (!cs_s) begin
          st_d = bus_wait;
          rd_d = rw_s;
          // only a control write answers fast
          wait_d = fast_req ? ACK_FAST_CYC - 4'h1 : ACK_SLOW_CYC - 4'h1;
          if (!addr_s[REGION_LINE_BIT]) begin
            rdata_d = ctrl_q;
            if (!rw_s) begin
              ctrl_d = data_s;
            end
          end else begin
            rdata_d = port_read(split, msel, dm_q[idx], cml_q[idx], cmh_q[idx]);
            // data memory and the unused code take no writes
            if (!rw_s) begin
              case (msel)
                MSEL_LOW:  cml_d[idx] = data_s;
                MSEL_HIGH: cmh_d[idx] = data_s[CMH_WIDTH-1:0];
                default:   cml_d[idx] = cml_q[idx];
              endcase
            end
          end
        end
      end
      bus_wait: begin
        if (wait_q == 4'h0) begin
          st_d = bus_ack;
        end else begin
          wait_d = wait_q - 4'h1;
        end
      end
      bus_ack: begin
        if (cs_s) begin
          st_d = bus_idle;
        end
      end
      default: st_d = bus_idle;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q    <= bus_idle;
      wait_q  <= 4'h0;
      ctrl_q  <= CTRL_RESET;
      rdata_q <= 8'h00;
      rd_q    <= 1'b0;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        cml_q[i] <= CML_RESET;
        cmh_q[i] <= CMH_RESET;
      end
    end else begin
      st_q    <= st_d;
      wait_q  <= wait_d;
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
      rd_q    <= rd_d;
      cml_q   <= cml_d;
      cmh_q   <= cmh_d;
    end
  end

  // ack held until the processor drops select
  assign data_o    = rdata_q;
  assign data_oe_o = (st_q == bus_ack) & rd_q;
  assign ack_n_o   = ~(st_q == bus_ack);
  assign ack_oe_o  = ~cs_s;

  // ----------------------------------------------------------------
  // transmit and external control
  // ----------------------------------------------------------------
  logic [7:0] byte_q [NSTREAM];
  logic [7:0] byte_d [NSTREAM];
  logic [7:0] en_q;
  logic [7:0] en_d;
  logic [7:0] bit_q;
  logic [7:0] bit_d;
  logic [7:0] cco_q;
  logic [7:0] cco_d;
  logic       cco_bit_q;
  logic       cco_bit_d;

  // {enable, byte} for one output channel
  function automatic logic [8:0] out_word(input logic       frc,
                                          input logic [2:0] channel_control_high,
                                          input logic [7:0] channel_source_low,
                                          input logic [7:0] dm_src);
    logic [8:0] w;
    w = 9'h000;
    // forcing acts as source and enable bits both set
    if (frc | channel_control_high[CMH_SRC_BIT]) begin
      w[7:0] = channel_source_low;
    end else begin
      w[7:0] = dm_src;
    end
    w[8] = frc | channel_control_high[CMH_OE_BIT];
    return w;
  endfunction

  always_comb begin
    logic [8:0] w;
    logic [7:0] src;
    w         = 9'h000;
    src       = 8'h00;
    byte_d    = byte_q;
    en_d      = en_q;
    bit_d     = bit_q;
    cco_d     = cco_q;
    cco_bit_d = cco_bit_q;
    if (tx_tick) begin
      if (tim.bitpos == 3'h0) begin
        for (int s = 0; s < NSTREAM; s++) begin
          // source address: stream in 7-5, channel in 4-0
          src = {cml_q[{3'(s), tim.chan}][CML_STREAM_HI:CML_STREAM_LO],
                 cml_q[{3'(s), tim.chan}][CML_CHAN_HI:CML_CHAN_LO]};
          w = out_word(force_out, cmh_q[{3'(s), tim.chan}],
                       cml_q[{3'(s), tim.chan}], dm_q[src]);
          byte_d[s] = w[7:0];
          en_d[s]   = w[8];
          bit_d[s]  = w[7];
          cco_d[s]  = cmh_q[{3'(s), next_chan}][CMH_EXT_BIT];
        end
        // channel 31 bit 0 carries stream 0 channel 0 of the next frame
        cco_bit_d = cmh_q[{3'h0, next_chan}][CMH_EXT_BIT];
      end else begin
        for (int s = 0; s < NSTREAM; s++) begin
          bit_d[s] = byte_q[s][3'h7 - tim.bitpos];
        end
        cco_bit_d = cco_q[tim.bitpos];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int s = 0; s < NSTREAM; s++) begin
        byte_q[s] <= 8'h00;
      end
      en_q      <= 8'h00;
      bit_q     <= 8'h00;
      cco_q     <= 8'h00;
      cco_bit_q <= 1'b0;
    end else begin
      byte_q    <= byte_d;
      en_q      <= en_d;
      bit_q     <= bit_d;
      cco_q     <= cco_d;
      cco_bit_q <= cco_bit_d;
    end
  end

  assign serial_outputs_o       = bit_q;
  assign serial_outputs_oe_o    = en_q & {8{ode_s}};
  assign external_control_bit_o = cco_bit_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_fast_wait;
    (st_q == bus_wait) [*2] ##1 (st_q == bus_ack);
  endsequence

  sequence s_slow_wait;
    (st_q == bus_wait) [*8] ##1 (st_q == bus_ack);
  endsequence

  a_fast_ack_time: assert property (fast_req |=> s_fast_wait)
    else $error("control write not answered after two wait cycles");

  a_slow_ack_time: assert property (take && !fast_req |=> s_slow_wait)
    else $error("slow access not answered after eight wait cycles");

  a_ctrl_write_take: assert property (fast_req |=> ctrl_q == $past(data_s))
    else $error("control register did not take written byte");

  a_ctrl_read_back: assert property (
    take && rw_s && !addr_s[REGION_LINE_BIT] |=> ##2 data_o == ctrl_q)
    else $error("control read did not return register value");

  a_cmh_upper_zero: assert property (
    take && rw_s && addr_s[REGION_LINE_BIT] && !split && msel == MSEL_HIGH
    |=> rdata_q[7:3] == 5'h00)
    else $error("control high upper bits not zero");

  a_ode_hiz: assert property (!ode_s && en_q != 8'h00 |-> serial_outputs_oe_o == 8'h00)
    else $error("serial output driven while master drive low");

  a_forced_drive: assert property (
    tx_tick && tim.bitpos == 3'h0 && force_out |=> en_q == 8'hff)
    else $error("forced output did not enable every channel");

  a_forced_content: assert property (
    tx_tick && tim.bitpos == 3'h0 && force_out
    |=> byte_q[0] == $past(cml_q[{3'h0, tim.chan}]))
    else $error("forced output byte differs from source low");

  a_cco_lead: assert property (
    tx_tick && tim.bitpos == 3'h0
    |=> external_control_bit_o == $past(cmh_q[{3'h0, next_chan}][CMH_EXT_BIT]))
    else $error("external control bit not one channel ahead");

  a_cco_order: assert property (
    tx_tick && tim.bitpos == 3'h3 |=> external_control_bit_o == $past(cco_q[3]))
    else $error("external control bits out of stream order");

endmodule

/* File: bench/serial_partner.sv */
`timescale 1ns/1ps
// ----------------------------------------
// serial link partner: bit clock, frame pulse, input streams
// ----------------------------------------
module serial_partner #(
  parameter logic [7:0] PAT = 8'h96
) (
  output logic       bclk_o,
  output logic       fp_n_o,
  output logic [7:0] sin_o,
  output logic [8:0] cnt_o
);
  // half period of 122 ns never meets an mclk edge at x.5 ns
  initial begin
    bclk_o = 1'b1;
    fp_n_o = 1'b1;
    cnt_o  = 9'h1fe;
    sin_o  = PAT;
    forever begin
      #122;
      cnt_o  = cnt_o + 9'h001;
      // byte flips per channel so the chosen source channel matters
      sin_o  = PAT ^ {8{cnt_o[4]}};
      bclk_o = 1'b0;
      #122;
      bclk_o = 1'b1;
      fp_n_o = (cnt_o != 9'h1ff);
    end
  end
endmodule

/* File: bench/tsi_switch_control_memory_map_test.sv */
`timescale 1ns/1ps
module tsi_switch_control_memory_map_test import tsi_pkg::*; ;
  localparam logic [7:0] PAT        = 8'h96;
  localparam int         SYNC_EDGES = 2;
  logic       mclk, nrst_n, cs_n, rd_wr, rdata_oe, ack_n, ack_oe;
  logic       bclk, fp_n, drive, ext;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, sin, tx, tx_oe, got;
  logic [8:0] pcnt;
  logic [7:0] cml_m [256];
  logic [7:0] cmh_m [256];
  int         n_fail, n_checks;

  tsi_switch_control_memory_map u_dut (
    .mclk_i                 (mclk),
    .nrst_i                 (nrst_n),
    .cs_n_i                 (cs_n),
    .rd_wr_i                (rd_wr),
    .addr_i                 (addr),
    .data_i                 (wdata),
    .data_o                 (rdata),
    .data_oe_o              (rdata_oe),
    .ack_n_o                (ack_n),
    .ack_oe_o               (ack_oe),
    .serial_bit_clock_i     (bclk),
    .frame_pulse_n_i        (fp_n),
    .serial_inputs_i        (sin),
    .master_output_drive_i  (drive),
    .serial_outputs_o       (tx),
    .serial_outputs_oe_o    (tx_oe),
    .external_control_bit_o (ext)
  );

  serial_partner #(.PAT(PAT)) u_link (
    .bclk_o (bclk),
    .fp_n_o (fp_n),
    .sin_o  (sin),
    .cnt_o  (pcnt)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // checks and bus cycles
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic acc(input logic rw, input logic [5:0] a, input logic [7:0] wd);
    int n;
    int exp_n;
    // two sync flops, take edge, wait cycles; ack is seen one edge after it is set
    exp_n = SYNC_EDGES + 2;
    exp_n += (!a[REGION_LINE_BIT] && !rw) ? int'(ACK_FAST_CYC) : int'(ACK_SLOW_CYC);
    @(posedge mclk);
    cs_n  <= 1'b0;
    rd_wr <= rw;
    addr  <= a;
    wdata <= wd;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack_n !== 1'b0 && n < 40);
    if (ack_n !== 1'b0) begin
      n_fail++;
      complete_run();
    end
    chk("ack cycles", 8'(exp_n), 8'(n));
    chk("ack drive", 8'h01, {7'h00, ack_oe});
    if (rw) chk("read drive", 8'h01, {7'h00, rdata_oe});
    got = rdata;
    cs_n <= 1'b1;
    n = 0;
    while (ack_n !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 40) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    acc(1'b0, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
    acc(1'b1, a, 8'h00);
    chk(what, exp, got);
  endtask

  task automatic prog(input logic [2:0] s, input logic [4:0] c, input logic [7:0] hi,
                      input logic [7:0] lo);
    wr(6'h00, {3'h0, MSEL_HIGH, s});
    wr({1'b1, c}, hi);
    wr(6'h00, {3'h0, MSEL_LOW, s});
    wr({1'b1, c}, lo);
    cmh_m[{s, c}] = {5'h00, hi[2:0]};
    cml_m[{s, c}] = lo;
  endtask

  // walk the link from frame start, checking each settled output bit from count first to last
  task automatic walk(input int first, input int last, input logic forced);
    int         p;
    int         s;
    int         k;
    logic [4:0] c;
    logic [2:0] b;
    logic [7:0] lo, hi, eoe, etx;
    k = 0;
    while (pcnt !== 9'h000 && k < 600) begin
      @(negedge bclk);
      k++;
    end
    if (k >= 600) begin
      n_fail++;
      complete_run();
    end
    for (p = 1; p <= last; p++) begin
      @(negedge bclk);
      if (p[0] && p >= first) begin
        c = p[8:4];
        b = 3'd7 - p[3:1];
        for (s = 0; s < 8; s++) begin
          lo = cml_m[{s[2:0], c}];
          hi = cmh_m[{s[2:0], c}];
          eoe[s] = drive & (forced | hi[0]);
          etx[s] = (forced | hi[2]) ? lo[b] : PAT[lo[7:5]] ^ lo[0];
        end
        chk("output enable", eoe, tx_oe);
        chk("output data", etx & eoe, tx & eoe);
        chk("external control", {7'h00, cmh_m[{p[3:1], c + 5'd1}][1]}, {7'h00, ext});
      end
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_fail   = 0;
    n_checks = 0;
    nrst_n   = 1'b0;
    cs_n     = 1'b1;
    rd_wr    = 1'b1;
    addr     = 6'h00;
    wdata    = 8'h00;
    drive    = 1'b0;
    for (int i = 0; i < 256; i++) begin
      cml_m[i] = 8'h00;
      cmh_m[i] = 8'h00;
    end
    repeat (5) @(posedge mclk);
    nrst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(6'h00, CTRL_RESET, "mode reset");
    chk("drive off", 8'h00, tx_oe);
    wr(6'h1f, 8'hab);
    rd(6'h00, 8'hab, "mode readback");
    $display("test registers done");
    prog(3'd0, 5'd0, 8'h07, 8'h5c);
    prog(3'd2, 5'd1, 8'h03, 8'h24);
    prog(3'd3, 5'd5, 8'h01, 8'hc9);
    prog(3'd7, 5'd31, 8'h06, 8'ha3);
    prog(3'd4, 5'd2, 8'h00, 8'h3c);
    prog(3'd5, 5'd6, 8'hff, 8'h00);
    wr(6'h00, {3'h0, MSEL_HIGH, 3'd5});
    rd(6'h26, 8'h07, "high unused bits");
    wr(6'h00, {3'h0, MSEL_LOW, 3'd2});
    rd(6'h21, 8'h24, "low readback");
    $display("test memory setup done");
    drive <= 1'b1;
    walk(1, 511, 1'b0);
    $display("test connection frame done");
    wr(6'h00, {3'h0, MSEL_DATA, 3'd1});
    wr(6'h24, 8'h55);
    rd(6'h24, {8{PAT[1]}}, "data memory");
    wr(6'h00, {3'h4, MSEL_LOW, 3'd6});
    wr(6'h29, 8'h11);
    rd(6'h29, {8{~PAT[6]}}, "split read");
    wr(6'h00, {3'h0, MSEL_LOW, 3'd6});
    rd(6'h29, 8'h11, "split write");
    cml_m[{3'd6, 5'd9}] = 8'h11;
    $display("test access modes done");
    wr(6'h00, {3'h2, MSEL_LOW, 3'd0});
    walk(17, 95, 1'b1);
    drive <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("drive low", 8'h00, tx_oe);
    $display("test forced output done");
    complete_run();
  end
endmodule
